// file: bench/cpu_model.sv
// CPU core and interrupt controller model facing the guard
`timescale 1ns/1ns
module cpu_model (
  input  wire logic        aclk,
  input  wire logic        resume_service,
  input  wire logic        resume_plain,
  output logic             ext_guarded_wr,
  output logic             mem_wr_strobe,
  output logic [23:0]      mem_wr_addr,
  output logic             halt_exec,
  output logic             nmi_req,
  output logic [3:0]       ext_pin_irqs,
  output logic             key_wakeup_irq,
  output logic             rtc_tick_irq,
  output logic [4:0]       alarm_irqs,
  output logic             other_irq,
  output logic [2:0]       irq_level,
  output logic [2:0]       cpu_mask
);
  initial begin
    {ext_guarded_wr, mem_wr_strobe, halt_exec, nmi_req, key_wakeup_irq, rtc_tick_irq, other_irq} = 7'h00;
    {ext_pin_irqs, alarm_irqs, irq_level, cpu_mask} = 15'h0000;
    mem_wr_addr = 24'h000000;
  end
  // One-cycle strobe: 0 guarded write, 1 memory write, 2 halt
  task automatic strobe(input int k, input logic [23:0] a);
    @(posedge aclk);
    mem_wr_addr <= a;
    {ext_guarded_wr, mem_wr_strobe, halt_exec} <= {k == 0, k == 1, k == 2};
    @(posedge aclk);
    {ext_guarded_wr, mem_wr_strobe, halt_exec} <= 3'h0;
    // Address is only valid with the strobe, so show garbage after it
    mem_wr_addr <= ~a;
  endtask : strobe
  // Request stays a level until answered or given up; 0 other, 1 rtc, 2 nmi, 3 key, 4 pin, 5 alarm
  task automatic wake(input int s, input logic [2:0] lvl, input logic [2:0] msk, input int max);
    int n;
    n = 0;
    @(posedge aclk);
    irq_level <= lvl;
    cpu_mask <= msk;
    {other_irq, rtc_tick_irq, nmi_req, key_wakeup_irq} <= 4'h8 >> s;
    ext_pin_irqs <= {3'h0, s == 4};
    alarm_irqs <= {4'h0, s == 5};
    while (n < max && !(resume_service || resume_plain)) begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
    {other_irq, rtc_tick_irq, nmi_req, key_wakeup_irq} <= 4'h0;
    ext_pin_irqs <= 4'h0;
    alarm_irqs <= 5'h00;
    irq_level <= 3'h0;
  endtask : wake
endmodule : cpu_model

// file: bench/standby_and_runaway_guard_tb.sv
// Self-checking bench for the standby controller and runaway guard
`timescale 1ns/1ns
module standby_and_runaway_guard_tb;
  import guard_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic        ext_guarded_wr, mem_wr_strobe, halt_exec, nmi_req, key_wakeup_irq, rtc_tick_irq, other_irq;
  logic [23:0] mem_wr_addr;
  logic [3:0]  ext_pin_irqs;
  logic [4:0]  alarm_irqs, unit_run;
  logic [2:0]  irq_level, cpu_mask;
  logic        protect_active, protect_violation_irq, rom_write_violation_irq, cpu_halt, periph_clk_en;
  logic        osc_run, clk_out_en, run_high_speed, pin_hold_active, pin_drive_sel, pin_drive_en;
  logic        resume_service, resume_plain, wake_held;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0, n_pv = 0, n_rv = 0, n_srv = 0, n_pln = 0;

  standby_and_runaway_guard #(.WUP_CYC_14(32), .WUP_CYC_16(64)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_guarded_wr, .mem_wr_strobe, .mem_wr_addr, .halt_exec, .nmi_req, .ext_pin_irqs,
    .key_wakeup_irq, .rtc_tick_irq, .alarm_irqs, .other_irq, .irq_level, .cpu_mask,
    .protect_active, .protect_violation_irq, .rom_write_violation_irq, .cpu_halt, .periph_clk_en,
    .unit_run, .osc_run, .clk_out_en, .run_high_speed, .pin_hold_active, .pin_drive_sel,
    .pin_drive_en, .resume_service, .resume_plain, .wake_held);
  cpu_model cpu (
    .aclk, .resume_service, .resume_plain, .ext_guarded_wr, .mem_wr_strobe, .mem_wr_addr,
    .halt_exec, .nmi_req, .ext_pin_irqs, .key_wakeup_irq, .rtc_tick_irq, .alarm_irqs,
    .other_irq, .irq_level, .cpu_mask);

  always #50 aclk = ~aclk;
  // Pulses last one cycle, so count them rather than poll them
  always @(posedge aclk) begin
    cyc++;
    n_pv += (protect_violation_irq === 1'b1);
    n_rv += (rom_write_violation_irq === 1'b1);
    n_srv += (resume_service === 1'b1);
    n_pln += (resume_plain === 1'b1);
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rst();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic halt_wait();
    cpu.strobe(2, 24'h0);
    repeat (8) @(posedge aclk);
  endtask : halt_wait

  initial begin
    int i, j, n, w;
    rst();
    rdr(OFS_STANDBY);
    chk(rd, 32'h0000000B);
    rdr(OFS_DRIVE_PROT);
    chk(rd, 32'h0);
    wr(OFS_FIRST_KEY, 32'h5A);
    wr(OFS_OSC, 32'h1);
    wr(OFS_SECOND_KEY, 32'hA5);
    chk(protect_active, 1'b0);
    wr(OFS_FIRST_KEY, 32'h5A);
    wr(OFS_SECOND_KEY, 32'hA5);
    rdr(OFS_DRIVE_PROT);
    chk(rd, 32'h1);
    wr(OFS_STANDBY, 32'h3F);
    rdr(OFS_STANDBY);
    chk(rd, 32'h0000000B);
    cpu.strobe(0, 24'h0);
    repeat (2) @(posedge aclk);
    chk(n_pv, 2);
    wr(8'h40, 32'h0);
    chk(resp, RESP_SLVERR);
    wr(OFS_FIRST_KEY, 32'hA5);
    wr(OFS_SECOND_KEY, 32'h5A);
    rdr(OFS_DRIVE_PROT);
    chk(rd, 32'h0);
    for (i = 0; i < 3; i++) begin
      wr(OFS_ROM_DETECT, 32'h1 << i);
      for (j = 0; j < 4; j++) cpu.strobe(1, {j[1:0], 22'h2AAAAA});
      rdr(OFS_ROM_DETECT);
      chk(rd, (32'h11 << i));
      wr(OFS_ROM_DETECT, 32'h0);
    end
    rdr(OFS_ROM_DETECT);
    chk(rd, 32'h0);
    chk(n_rv, 3);
    wr(OFS_STANDBY, 32'h543);
    halt_wait();
    chk({cpu_halt, periph_clk_en, unit_run}, 7'h75);
    cpu.wake(0, 3'h5, 3'h3, 20);
    chk(n_srv, 1);
    rdr(OFS_STANDBY);
    chk(rd, 32'h543);
    halt_wait();
    cpu.wake(0, 3'h1, 3'h5, 12);
    chk(cpu_halt, 1'b1);
    cpu.wake(1, 3'h1, 3'h5, 20);
    chk(n_pln, 1);
    wr(OFS_STANDBY, 32'h32);
    halt_wait();
    chk({periph_clk_en, unit_run, pin_hold_active, pin_drive_sel, pin_drive_en, osc_run}, 10'h00F);
    cpu.wake(0, 3'h5, 3'h3, 12);
    chk(cpu_halt, 1'b1);
    cpu.wake(1, 3'h1, 3'h5, 20);
    chk(n_pln, 2);
    cpu.strobe(2, 24'h0);
    cpu.wake(4, 3'h1, 3'h5, 2);
    repeat (6) @(posedge aclk);
    chk({cpu_halt, wake_held}, 2'h3);
    cpu.wake(3, 3'h1, 3'h5, 20);
    chk({n_pln[30:0], wake_held}, 32'h6);
    for (i = 1; i < 4; i++) begin
      // Only the middle pass wakes on the fast clock, so both settings are seen
      wr(OFS_OSC, (i == 2) ? 32'h1 : 32'h0);
      wr(OFS_STANDBY, (i << 2) | 1);
      halt_wait();
      chk(osc_run, 1'b0);
      cpu.wake(5, 3'h1, 3'h5, 12);
      chk(cpu_halt, 1'b1);
      cpu.wake(2, 3'h7, 3'h7, 20);
      w = (i == 1) ? 256 : (i == 2) ? 32 : 64;
      n = 0;
      while (clk_out_en !== 1'b1 && n < 400) begin
        @(posedge aclk);
        n++;
      end
      chk({n > w - 4, n <= w + 2, run_high_speed}, {2'h3, i == 2});
    end
    chk(n_srv, 4);
    halt_wait();
    rst();
    @(posedge aclk);
    chk({cpu_halt, run_high_speed}, 2'h1);
    rdr(OFS_STANDBY);
    chk(rd, 32'h0000000B);
    test_done();
  end
endmodule : standby_and_runaway_guard_tb

// file: verilog/guard_pkg.sv
// Shared constants for the standby controller and runaway guard
package guard_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          BUS_ADDR_W      = 24;
  localparam int          IRQ_W           = 13;
  // Byte addresses of the registers
  localparam logic [7:0]  OFS_DRIVE_PROT  = 8'h00;
  localparam logic [7:0]  OFS_FIRST_KEY   = 8'h04;
  localparam logic [7:0]  OFS_SECOND_KEY  = 8'h08;
  localparam logic [7:0]  OFS_ROM_DETECT  = 8'h0C;
  localparam logic [7:0]  OFS_STANDBY     = 8'h10;
  localparam logic [7:0]  OFS_OSC         = 8'h14;
  // Key bytes
  localparam logic [7:0]  KEY_5A          = 8'h5A;
  localparam logic [7:0]  KEY_A5          = 8'hA5;
  // drive_protect_ctrl fields
  localparam int          PROT_BIT        = 0;
  // rom_detect_ctrl fields: enables [2:0], hit flags [6:4]
  localparam int          EN_LSB          = 0;
  localparam int          HIT_LSB         = 4;
  localparam logic [1:0]  WIN_FLASH       = 2'h1;
  localparam logic [1:0]  WIN_DATA        = 2'h2;
  localparam logic [1:0]  WIN_PROG        = 2'h3;
  // standby_ctrl fields
  localparam int          HALT_LSB        = 0;
  localparam int          WUP_LSB         = 2;
  localparam int          DRV_SEL_BIT     = 4;
  localparam int          DRV_EN_BIT      = 5;
  localparam int          IDLE_RUN_LSB    = 6;
  localparam int          UNIT_N          = 5;
  localparam int          STATE_LSB       = 16;
  localparam logic [10:0] STANDBY_RST     = 11'h00B;
  localparam logic [10:0] STANDBY_MASK    = 11'h7FF;
  // osc_ctrl fields
  localparam int          WAKE_HS_BIT     = 0;
  localparam logic [0:0]  OSC_RST         = 1'h1;
  // Halt mode and warm-up encodings
  localparam logic [1:0]  MODE_LIGHT      = 2'h3;
  localparam logic [1:0]  MODE_DEEP       = 2'h2;
  localparam logic [1:0]  MODE_STOP       = 2'h1;
  localparam logic [1:0]  WUP_8           = 2'h1;
  localparam logic [1:0]  WUP_14          = 2'h2;
  localparam int          WUP_CNT_W       = 17;
  localparam logic [16:0] WUP_CYC_8       = 17'h00100;
  localparam int          WUP_CYC_14_DEF  = 16384;
  localparam int          WUP_CYC_16_DEF  = 65536;
  localparam logic [2:0]  ENTRY_CYC       = 3'h5;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  typedef enum logic [1:0] {ST_RUN, ST_ENTER, ST_HALT, ST_WARMUP} sb_state_t;
endpackage : guard_pkg

// file: verilog/standby_and_runaway_guard.sv
// Standby controller, register write guard and ROM write detector
// Function
// - key one: 5AH then A5H, consecutive
// - key two: A5H then 5AH, consecutive
// - read-only protection status bit
// - protection inactive after reset
// - guarded write while protected raises violation
// - guarded set covers clock, standby, detect registers
// - three fixed ROM address windows decoded
// - per-window enable; enabled hit raises interrupt
// - per-window hit flag, cleared by zero
// - halt instruction enters mode from field
// - light idle: units follow idle-run bits
// - deep idle: only oscillator, RTC, melody run
// - stop: everything including oscillator stops
// - pins follow drive bits in deep/stop
// - enabled interrupt releases and gets serviced
// - special sources release masked, no service
// - NMI always releases and is serviced
// - release sources depend on halt mode
// - stop exit waits selected warm-up count
// - wake clock select after stop exit
// - reset leaves halt, restores default settings
// - requests sampled async, restart synchronous
// - request during entry held; later one releases
// - protected guarded write is blocked
`timescale 1ns/1ns
module standby_and_runaway_guard #(
  parameter int WUP_CYC_14 = guard_pkg::WUP_CYC_14_DEF,
  parameter int WUP_CYC_16 = guard_pkg::WUP_CYC_16_DEF
) (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic [guard_pkg::ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [guard_pkg::DATA_W-1:0]      s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [guard_pkg::ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [guard_pkg::DATA_W-1:0]           s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic                              ext_guarded_wr,
  input  wire logic                              mem_wr_strobe,
  input  wire logic [guard_pkg::BUS_ADDR_W-1:0]  mem_wr_addr,
  input  wire logic                              halt_exec,
  input  wire logic                              nmi_req,
  input  wire logic [3:0]                        ext_pin_irqs,
  input  wire logic                              key_wakeup_irq,
  input  wire logic                              rtc_tick_irq,
  input  wire logic [4:0]                        alarm_irqs,
  input  wire logic                              other_irq,
  input  wire logic [2:0]                        irq_level,
  input  wire logic [2:0]                        cpu_mask,
  output logic                                   protect_active,
  output logic                                   protect_violation_irq,
  output logic                                   rom_write_violation_irq,
  output logic                                   cpu_halt,
  output logic                                   periph_clk_en,
  output logic [guard_pkg::UNIT_N-1:0]           unit_run,
  output logic                                   osc_run,
  output logic                                   clk_out_en,
  output logic                                   run_high_speed,
  output logic                                   pin_hold_active,
  output logic                                   pin_drive_sel,
  output logic                                   pin_drive_en,
  output logic                                   resume_service,
  output logic                                   resume_plain,
  output logic                                   wake_held
);
  import guard_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  function automatic logic is_guarded(input logic [7:0] a);
    is_guarded = (a == OFS_DRIVE_PROT) || (a == OFS_ROM_DETECT) || (a == OFS_STANDBY) || (a == OFS_OSC);
  endfunction : is_guarded

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_guarded(a) || (a == OFS_FIRST_KEY) || (a == OFS_SECOND_KEY);
  endfunction : is_mapped

  localparam logic [16:0] WUP_C14 = 17'(WUP_CYC_14);
  localparam logic [16:0] WUP_C16 = 17'(WUP_CYC_16);

  logic                  wr_fire;
  logic                  rd_fire;
  logic                  key_half1;
  logic                  key_half2;
  logic                  blocked;
  logic [2:0]            rom_en;
  logic [2:0]            rom_hit;
  logic [2:0]            win_sel;
  logic [10:0]           standby_ctrl;
  logic [0:0]            osc_ctrl;
  logic [IRQ_W-1:0]      irq_meta;
  logic [IRQ_W-1:0]      irq_sync;
  logic [IRQ_W-1:0]      irq_prev;
  sb_state_t             state;
  logic [1:0]            mode;
  logic [2:0]            entry_cnt;
  logic [16:0]           wup_cnt;
  logic [16:0]           wup_target;
  logic                  enabled;
  logic                  sp_deep;
  logic                  sp_stop;
  logic                  any_mask;
  logic                  wake_lvl;
  logic                  wake_rise;
  logic                  serve;
  logic                  release_ok;
  logic [31:0]           rd_word;
  logic [31:0]           wr_word;

  assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign blocked = protect_active && is_guarded(s_axi_awaddr);

  // Bus slave: address and data are taken together, one transfer at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    case (s_axi_araddr)
      OFS_DRIVE_PROT: rd_word[PROT_BIT] = protect_active;
      OFS_ROM_DETECT: begin
        rd_word[EN_LSB +: 3]  = rom_en;
        rd_word[HIT_LSB +: 3] = rom_hit;
      end
      OFS_STANDBY: begin
        rd_word[10:0]            = standby_ctrl;
        rd_word[STATE_LSB +: 2] = state;
      end
      OFS_OSC: rd_word[0] = osc_ctrl[0];
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Key detector: half-key survives only until the very next bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_half1      <= 1'b0;
      key_half2      <= 1'b0;
      protect_active <= 1'b0;
    end else if (wr_fire) begin
      key_half1 <= s_axi_wstrb[0] && s_axi_awaddr == OFS_FIRST_KEY && s_axi_wdata[7:0] == KEY_5A;
      key_half2 <= s_axi_wstrb[0] && s_axi_awaddr == OFS_FIRST_KEY && s_axi_wdata[7:0] == KEY_A5;
      if (s_axi_wstrb[0] && s_axi_awaddr == OFS_SECOND_KEY) begin
        if (key_half1 && s_axi_wdata[7:0] == KEY_A5) begin
          protect_active <= 1'b1;
        end else if (key_half2 && s_axi_wdata[7:0] == KEY_5A) begin
          protect_active <= 1'b0;
        end
      end
    end
  end

  // Violation pulse covers local guarded registers and the external ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      protect_violation_irq <= 1'b0;
    end else begin
      protect_violation_irq <= (wr_fire && blocked) || (protect_active && ext_guarded_wr);
    end
  end

  // Guarded settings
  assign wr_word = merge(32'(standby_ctrl), s_axi_wdata, s_axi_wstrb);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_ctrl <= STANDBY_RST;
      osc_ctrl     <= OSC_RST;
    end else if (wr_fire && !blocked) begin
      if (s_axi_awaddr == OFS_STANDBY) begin
        standby_ctrl <= wr_word[10:0] & STANDBY_MASK;
      end
      if (s_axi_awaddr == OFS_OSC && s_axi_wstrb[0]) begin
        osc_ctrl <= s_axi_wdata[0:0];
      end
    end
  end

  // ROM write detector; a hit in the clearing cycle wins over the clear
  always_comb begin
    win_sel = 3'b000;
    case (mem_wr_addr[23:22])
      WIN_FLASH: win_sel = 3'b001;
      WIN_DATA:  win_sel = 3'b010;
      WIN_PROG:  win_sel = 3'b100;
      default:   win_sel = 3'b000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rom_en                  <= 3'b000;
      rom_hit                 <= 3'b000;
      rom_write_violation_irq <= 1'b0;
    end else begin
      rom_write_violation_irq <= mem_wr_strobe && |(win_sel & rom_en);
      if (wr_fire && !blocked && s_axi_awaddr == OFS_ROM_DETECT && s_axi_wstrb[0]) begin
        rom_en  <= s_axi_wdata[EN_LSB +: 3];
        rom_hit <= (rom_hit & s_axi_wdata[HIT_LSB +: 3]) | ({3{mem_wr_strobe}} & win_sel & rom_en);
      end else begin
        rom_hit <= rom_hit | ({3{mem_wr_strobe}} & win_sel & rom_en);
      end
    end
  end

  // Wake requests may come from an unclocked domain during halt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_meta <= '0;
      irq_sync <= '0;
      irq_prev <= '0;
    end else begin
      irq_meta <= {other_irq, alarm_irqs, rtc_tick_irq, key_wakeup_irq, ext_pin_irqs, nmi_req};
      irq_sync <= irq_meta;
      irq_prev <= irq_sync;
    end
  end

  assign mode      = standby_ctrl[HALT_LSB +: 2];
  assign enabled   = irq_level >= cpu_mask;
  assign sp_stop   = |irq_sync[5:1];
  assign sp_deep   = |irq_sync[11:1];
  assign any_mask  = |irq_sync[12:1];

  always_comb begin
    case (mode)
      MODE_LIGHT: begin
        wake_lvl  = irq_sync[0] || (any_mask && enabled) || sp_deep;
        wake_rise = |(irq_sync & ~irq_prev);
        serve     = irq_sync[0] || (any_mask && enabled);
      end
      MODE_DEEP: begin
        wake_lvl  = irq_sync[0] || sp_deep;
        wake_rise = |(irq_sync[11:0] & ~irq_prev[11:0]);
        serve     = irq_sync[0] || (sp_deep && enabled);
      end
      default: begin
        wake_lvl  = irq_sync[0] || sp_stop;
        wake_rise = |(irq_sync[5:0] & ~irq_prev[5:0]);
        serve     = irq_sync[0] || (sp_stop && enabled);
      end
    endcase
  end

  // A request held from the entry window needs a fresh one to release
  assign release_ok = wake_held ? (wake_rise && wake_lvl) : wake_lvl;

  always_comb begin
    case (standby_ctrl[WUP_LSB +: 2])
      WUP_14:  wup_target = WUP_C14;
      MODE_LIGHT: wup_target = WUP_C16;
      default: wup_target = WUP_CYC_8;
    endcase
  end

  // Halt sequencer; reset always lands in run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state          <= ST_RUN;
      entry_cnt      <= '0;
      wup_cnt        <= '0;
      wake_held      <= 1'b0;
      resume_service <= 1'b0;
      resume_plain   <= 1'b0;
      run_high_speed <= 1'b1;
    end else begin
      resume_service <= 1'b0;
      resume_plain   <= 1'b0;
      case (state)
        ST_RUN: begin
          if (halt_exec && mode == MODE_LIGHT) begin
            state <= ST_HALT;
          end else if (halt_exec && (mode == MODE_DEEP || mode == MODE_STOP)) begin
            state     <= ST_ENTER;
            entry_cnt <= '0;
          end
        end
        ST_ENTER: begin
          if (wake_lvl) begin
            wake_held <= 1'b1;
          end
          entry_cnt <= entry_cnt + 3'h1;
          if (entry_cnt == ENTRY_CYC - 3'h1) begin
            state <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (release_ok) begin
            wake_held      <= 1'b0;
            resume_service <= serve;
            resume_plain   <= !serve;
            if (mode == MODE_STOP) begin
              state   <= ST_WARMUP;
              wup_cnt <= '0;
            end else begin
              state <= ST_RUN;
            end
          end
        end
        ST_WARMUP: begin
          wup_cnt <= wup_cnt + 17'h1;
          if (wup_cnt == wup_target - 17'h1) begin
            state          <= ST_RUN;
            run_high_speed <= osc_ctrl[WAKE_HS_BIT];
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Registered stop controls toward the clock tree and peripherals
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_halt        <= 1'b0;
      periph_clk_en   <= 1'b1;
      unit_run        <= '1;
      osc_run         <= 1'b1;
      clk_out_en      <= 1'b1;
      pin_hold_active <= 1'b0;
      pin_drive_sel   <= 1'b0;
      pin_drive_en    <= 1'b0;
    end else begin
      cpu_halt        <= state != ST_RUN;
      periph_clk_en   <= !(state == ST_HALT && mode != MODE_LIGHT);
      osc_run         <= !(state == ST_HALT && mode == MODE_STOP);
      clk_out_en      <= !((state == ST_HALT && mode == MODE_STOP) || state == ST_WARMUP);
      pin_hold_active <= state == ST_HALT && mode != MODE_LIGHT;
      pin_drive_sel   <= standby_ctrl[DRV_SEL_BIT];
      pin_drive_en    <= standby_ctrl[DRV_EN_BIT];
      if (state == ST_HALT && mode == MODE_LIGHT) begin
        unit_run <= standby_ctrl[IDLE_RUN_LSB +: UNIT_N];
      end else if (state == ST_HALT) begin
        unit_run <= '0;
      end else begin
        unit_run <= '1;
      end
    end
  end

  key_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && key_half1 && s_axi_awaddr == OFS_SECOND_KEY && s_axi_wstrb[0] && s_axi_wdata[7:0] == KEY_A5
    |=> protect_active) else $error("first key did not enable protection");
  key_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && key_half2 && s_axi_awaddr == OFS_SECOND_KEY && s_axi_wstrb[0] && s_axi_wdata[7:0] == KEY_5A
    |=> !protect_active) else $error("second key did not disable protection");
  reset_prot_a: assert property (@(posedge aclk) !aresetn |=> !protect_active)
    else $error("protection active after reset");
  violation_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && protect_active && s_axi_awaddr == OFS_STANDBY |=> protect_violation_irq && $stable(standby_ctrl))
    else $error("guarded write not flagged or not blocked");
  rom_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_wr_strobe && mem_wr_addr[23:22] == WIN_PROG && rom_en[2] |=> rom_hit[2] && rom_write_violation_irq)
    else $error("program window hit not recorded");
  entry_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_RUN && halt_exec && mode == MODE_DEEP |=> state == ST_ENTER [*5] ##1 state == ST_HALT)
    else $error("entry window length wrong");
  stop_osc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_HALT && mode == MODE_STOP |=> !osc_run && !periph_clk_en)
    else $error("oscillator kept running in stop");
  warmup_short_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == ST_WARMUP) && standby_ctrl[WUP_LSB +: 2] == WUP_8 |-> ##255 state == ST_WARMUP ##1 state == ST_RUN)
    else $error("short warm-up count wrong");
  nmi_serve_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_HALT && !wake_held && irq_sync[0] |=> resume_service)
    else $error("nmi did not release halt with service");
endmodule : standby_and_runaway_guard
